// *** rtl/cmic_pkg.sv ***
// Constants for the comparator mode and edge interrupt control block.
// Assumes an 8-bit special-function-register bus in the system clock domain.
`default_nettype none
package cmic_pkg;
   // Register address on the SFR bus
   localparam logic [7:0] MODE_SEL_ADDR = 8'h9D;
   // Reset value of the mode register
   localparam logic [7:0] MODE_SEL_RESET = 8'h02;
   // Field positions
   localparam int RSV_BIT = 7;
   localparam int UNUSED_HI_BIT = 6;
   localparam int RISE_IE_BIT = 5;
   localparam int FALL_IE_BIT = 4;
   localparam int UNUSED_MSB = 3;
   localparam int UNUSED_LSB = 2;
   localparam int RESP_MSB = 1;
   localparam int RESP_LSB = 0;
   // Reset values of the individual fields
   localparam logic RISE_IE_RESET = MODE_SEL_RESET[RISE_IE_BIT];
   localparam logic FALL_IE_RESET = MODE_SEL_RESET[FALL_IE_BIT];
   localparam logic [1:0] RESP_RESET = MODE_SEL_RESET[RESP_MSB:RESP_LSB];
   // Response time codes
   localparam logic [1:0] RESP_FASTEST = 2'h0;
   localparam logic [1:0] RESP_MID_FAST = 2'h1;
   localparam logic [1:0] RESP_MID_LOW = 2'h2;
   localparam logic [1:0] RESP_LOW_POWER = 2'h3;
   // Value returned for unmapped reads and idle bus
   localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage
`default_nettype wire

// *** rtl/cmic_edge_if.sv ***
// Carrier between the control top and its edge flag unit.
// Assumes both ends run on the same system clock.
`default_nettype none
interface cmic_edge_if;
   logic cmp_out;
   logic rise_clr;
   logic fall_clr;
   logic rise_flag;
   logic fall_flag;
   // Flag unit side
   modport flag_unit (
      input cmp_out,
      input rise_clr,
      input fall_clr,
      output rise_flag,
      output fall_flag
   );
   // Control side
   modport ctrl (
      output cmp_out,
      output rise_clr,
      output fall_clr,
      input rise_flag,
      input fall_flag
   );
endinterface
`default_nettype wire

// *** rtl/cmic_edge_flags.sv ***
// Edge detector and sticky rising/falling flags for the comparator output.
// Assumes the comparator output is already synchronous to clk_sys.
`default_nettype none
module cmic_edge_flags (
   input wire logic clk_sys,
   input wire logic nrst,
   cmic_edge_if.flag_unit ifc
);
   logic cmp_prev;
   logic primed;
   logic next_cmp_prev;
   logic next_primed;
   logic next_rise;
   logic next_fall;
   logic rise_edge;
   logic fall_edge;

   ////////////////////////////////////////////////////////////////////////
   // Edge detection and flag update
   always_comb begin
      next_cmp_prev = ifc.cmp_out;
      // First sample after reset only primes, no false edge from reset value
      next_primed = 1'b1;
      rise_edge = primed & ~cmp_prev & ifc.cmp_out;
      fall_edge = primed & cmp_prev & ~ifc.cmp_out;
      // Set beats clear so an edge in the clear cycle is kept
      next_rise = rise_edge | (ifc.rise_flag & ~ifc.rise_clr);
      next_fall = fall_edge | (ifc.fall_flag & ~ifc.fall_clr);
   end

   // State registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmp_prev <= 1'b0;
         primed <= 1'b0;
         ifc.rise_flag <= 1'b0;
         ifc.fall_flag <= 1'b0;
      end else begin
         cmp_prev <= next_cmp_prev;
         primed <= next_primed;
         ifc.rise_flag <= next_rise;
         ifc.fall_flag <= next_fall;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_rise_set;
      @(posedge clk_sys) disable iff (!nrst)
      rise_edge |=> ifc.rise_flag;
   endproperty
   a_rise_set: assert property (p_rise_set) else $error("Rising edge did not set flag");

   property p_fall_sticky;
      @(posedge clk_sys) disable iff (!nrst)
      ifc.fall_flag && !ifc.fall_clr |=> ifc.fall_flag;
   endproperty
   a_fall_sticky: assert property (p_fall_sticky) else $error("Fall flag lost");

   property p_indep;
      @(posedge clk_sys) disable iff (!nrst)
      rise_edge && !ifc.fall_flag |=> !ifc.fall_flag;
   endproperty
   a_indep: assert property (p_indep) else $error("Rising edge set fall flag");

   c_rise: cover property (@(posedge clk_sys) disable iff (!nrst) rise_edge ##1 ifc.rise_flag);
   c_clr_race: cover property (@(posedge clk_sys) disable iff (!nrst) fall_edge && ifc.fall_clr);
endmodule
`default_nettype wire

// *** rtl/cmic_top.sv ***
// Comparator mode register with edge interrupt gating, on the SFR bus.
// Assumes one-cycle SFR read/write strobes; flag clears come from the
// comparator control register owned elsewhere.
`default_nettype none
// Summary of operation
// - Bit 7 reserved: reads 0, write 0
// - Bit 6 reads 0, writes ignored
// - Bits 3:2 read 0, writes discarded
// - Bit 5 enables rising-edge interrupt
// - Bit 4 enables falling-edge interrupt
// - Interrupt needs local and controller enables
// - Bits 1:0 select response time mode
// - Edge flags set on edge, sticky
// - Rising and falling handled independently
module cmic_top (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic cmp_out,
   input wire logic rise_flag_clr,
   input wire logic fall_flag_clr,
   input wire logic comparator_source_gate,
   output logic rise_edge_flag,
   output logic fall_edge_flag,
   output logic [1:0] response_time_sel,
   output logic cmp_irq_req
);
   cmic_edge_if ifc ();
   logic rise_irq_enable;
   logic fall_irq_enable;
   logic next_rise_ie;
   logic next_fall_ie;
   logic [1:0] next_resp;
   logic [7:0] next_rdata;
   logic next_irq;
   logic local_req;
   logic hit;
   logic [7:0] mode_view;

   ////////////////////////////////////////////////////////////////////////
   // Edge flag unit
   assign ifc.cmp_out = cmp_out;
   assign ifc.rise_clr = rise_flag_clr;
   assign ifc.fall_clr = fall_flag_clr;

   cmic_edge_flags u_flags (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ifc(ifc.flag_unit)
   );

   // Flags leave the block straight from the unit's flops
   assign rise_edge_flag = ifc.rise_flag;
   assign fall_edge_flag = ifc.fall_flag;

   ////////////////////////////////////////////////////////////////////////
   // Register file next state
   always_comb begin
      hit = (sfr_addr == cmic_pkg::MODE_SEL_ADDR);
      mode_view = 8'h00; // Bits 7, 6, 3, 2 stay zero
      mode_view[cmic_pkg::RISE_IE_BIT] = rise_irq_enable;
      mode_view[cmic_pkg::FALL_IE_BIT] = fall_irq_enable;
      mode_view[cmic_pkg::RESP_MSB:cmic_pkg::RESP_LSB] = response_time_sel;
      next_rise_ie = rise_irq_enable;
      next_fall_ie = fall_irq_enable;
      next_resp = response_time_sel;
      // Only live fields are stored; reserved and unused bits are dropped
      if (sfr_wr && hit) begin
         next_rise_ie = sfr_wdata[cmic_pkg::RISE_IE_BIT];
         next_fall_ie = sfr_wdata[cmic_pkg::FALL_IE_BIT];
         next_resp = sfr_wdata[cmic_pkg::RESP_MSB:cmic_pkg::RESP_LSB];
      end
      // Read data one cycle after the strobe; unmapped reads give zero
      next_rdata = (sfr_rd && hit) ? mode_view : cmic_pkg::RDATA_IDLE;
   end

   // Interrupt request: flags gated by local then controller enables
   always_comb begin
      local_req = (ifc.rise_flag & rise_irq_enable) | (ifc.fall_flag & fall_irq_enable);
      next_irq = local_req & comparator_source_gate;
   end

   // Registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rise_irq_enable <= cmic_pkg::RISE_IE_RESET;
         fall_irq_enable <= cmic_pkg::FALL_IE_RESET;
         response_time_sel <= cmic_pkg::RESP_RESET;
         sfr_rdata <= cmic_pkg::RDATA_IDLE;
         cmp_irq_req <= 1'b0;
      end else begin
         rise_irq_enable <= next_rise_ie;
         fall_irq_enable <= next_fall_ie;
         response_time_sel <= next_resp;
         sfr_rdata <= next_rdata;
         cmp_irq_req <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_rsv_zero;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_rd && hit |=> sfr_rdata[cmic_pkg::RSV_BIT] == 1'b0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bit read non-zero");

   property p_bit6_zero;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit && sfr_wdata[cmic_pkg::UNUSED_HI_BIT] ##1 sfr_rd && hit
         |=> sfr_rdata[cmic_pkg::UNUSED_HI_BIT] == 1'b0;
   endproperty
   a_bit6_zero: assert property (p_bit6_zero) else $error("Bit 6 kept a write");

   property p_unused_zero;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_rdata[cmic_pkg::UNUSED_MSB:cmic_pkg::UNUSED_LSB] == 2'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("Bits 3:2 read non-zero");

   property p_rise_ie;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit |=> rise_irq_enable == $past(sfr_wdata[cmic_pkg::RISE_IE_BIT]);
   endproperty
   a_rise_ie: assert property (p_rise_ie) else $error("Rise enable not written");

   property p_fall_block;
      @(posedge clk_sys) disable iff (!nrst)
      !fall_irq_enable && !rise_irq_enable |=> !cmp_irq_req;
   endproperty
   a_fall_block: assert property (p_fall_block) else $error("Request with enables off");

   property p_gate;
      @(posedge clk_sys) disable iff (!nrst)
      !comparator_source_gate |=> !cmp_irq_req;
   endproperty
   a_gate: assert property (p_gate) else $error("Request without controller enable");

   property p_resp;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit ##1 sfr_rd && hit
         |=> sfr_rdata[cmic_pkg::RESP_MSB:cmic_pkg::RESP_LSB]
             == $past(sfr_wdata[cmic_pkg::RESP_MSB:cmic_pkg::RESP_LSB], 2);
   endproperty
   a_resp: assert property (p_resp) else $error("Response select readback wrong");

   property p_irq;
      @(posedge clk_sys) disable iff (!nrst)
      local_req && comparator_source_gate |=> cmp_irq_req;
   endproperty
   a_irq: assert property (p_irq) else $error("Request missing");

   // Fall enable and response field land one cycle after a hit write
   property p_fall_ie;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit |=> fall_irq_enable == $past(sfr_wdata[cmic_pkg::FALL_IE_BIT]);
   endproperty
   a_fall_ie: assert property (p_fall_ie) else $error("Fall enable not written");

   property p_resp_wr;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit
         |=> response_time_sel == $past(sfr_wdata[cmic_pkg::RESP_MSB:cmic_pkg::RESP_LSB]);
   endproperty
   a_resp_wr: assert property (p_resp_wr) else $error("Response select not written");

   // Writes to other addresses must leave every field alone
   property p_hold;
      @(posedge clk_sys) disable iff (!nrst)
      !(sfr_wr && hit) |=> $stable(response_time_sel) && $stable(rise_irq_enable)
         && $stable(fall_irq_enable);
   endproperty
   a_hold: assert property (p_hold) else $error("Field changed without a hit write");

   // Bit 6 reads zero whatever was written before
   property p_bit6_read;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_rd && hit |=> sfr_rdata[cmic_pkg::UNUSED_HI_BIT] == 1'b0;
   endproperty
   a_bit6_read: assert property (p_bit6_read) else $error("Bit 6 read non-zero");

   // Outside a hit read the bus shows the idle value, so misses read zero
   property p_rdata_idle;
      @(posedge clk_sys) disable iff (!nrst)
      !(sfr_rd && hit) |=> sfr_rdata == cmic_pkg::RDATA_IDLE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not idle");

   property p_rdata_view;
      @(posedge clk_sys) disable iff (!nrst)
      sfr_rd && hit |=> sfr_rdata[cmic_pkg::RISE_IE_BIT] == $past(rise_irq_enable)
         && sfr_rdata[cmic_pkg::FALL_IE_BIT] == $past(fall_irq_enable);
   endproperty
   a_rdata_view: assert property (p_rdata_view) else $error("Enable readback wrong");

   // Each direction is blocked by its own enable alone
   property p_rise_block;
      @(posedge clk_sys) disable iff (!nrst)
      !rise_irq_enable && !(fall_irq_enable && ifc.fall_flag) |=> !cmp_irq_req;
   endproperty
   a_rise_block: assert property (p_rise_block) else $error("Rise request while off");

   property p_fall_only;
      @(posedge clk_sys) disable iff (!nrst)
      !fall_irq_enable && !(rise_irq_enable && ifc.rise_flag) |=> !cmp_irq_req;
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("Fall request while off");

   // No flag, no request, whatever the enables say
   property p_no_flag;
      @(posedge clk_sys) disable iff (!nrst)
      !ifc.rise_flag && !ifc.fall_flag |=> !cmp_irq_req;
   endproperty
   a_no_flag: assert property (p_no_flag) else $error("Request without a flag");

   // A raised request always had the controller gate behind it
   property p_gate_cause;
      @(posedge clk_sys) disable iff (!nrst)
      cmp_irq_req |-> $past(comparator_source_gate);
   endproperty
   a_gate_cause: assert property (p_gate_cause) else $error("Request with gate closed");

   c_irq: cover property (@(posedge clk_sys) disable iff (!nrst) !cmp_irq_req ##1 cmp_irq_req);
   c_lowpow: cover property (@(posedge clk_sys) disable iff (!nrst)
      response_time_sel == cmic_pkg::RESP_LOW_POWER);
   c_fall_irq: cover property (@(posedge clk_sys) disable iff (!nrst)
      ifc.fall_flag && fall_irq_enable ##1 cmp_irq_req);
endmodule
`default_nettype wire

// *** bench/cmic_far_model.sv ***
// Far-side model: comparator output level and interrupt controller gate.
// Assumes requests are driven by non-blocking assignment at clk_sys edges.
`default_nettype none
module cmic_far_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic flip_req,
   input wire logic gate_req,
   output logic cmp_out,
   output logic comparator_source_gate
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////////
   // Level only moves on request, so no spurious edges reach the detector
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmp_out <= 1'b0;
         comparator_source_gate <= 1'b0;
      end else begin
         cmp_out <= cmp_out ^ flip_req;
         comparator_source_gate <= gate_req;
      end
   end
endmodule
`default_nettype wire

// *** bench/cmic_top_bench.sv ***
// Self-checking bench for the comparator mode register and edge interrupt.
// Assumes the rtl package, interface and modules are compiled first.
`default_nettype none
module cmic_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, shadow = 8'h02;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, rise_flag_clr = 1'b0, fall_flag_clr = 1'b0;
   logic flip_req = 1'b0, gate_req = 1'b0, rd_pend = 1'b0;
   logic cmp_out, comparator_source_gate, rise_edge_flag, fall_edge_flag, cmp_irq_req;
   logic [1:0] response_time_sel;
   logic [7:0] exp_q[$];
   logic [31:0] r;
   int err_total = 0;
   int num_checks = 0;
   int seed = 32'h81e6;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and instances
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   cmic_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp_out(cmp_out),
      .rise_flag_clr(rise_flag_clr), .fall_flag_clr(fall_flag_clr),
      .comparator_source_gate(comparator_source_gate), .rise_edge_flag(rise_edge_flag),
      .fall_edge_flag(fall_edge_flag), .response_time_sel(response_time_sel),
      .cmp_irq_req(cmp_irq_req));
   cmic_far_model i_far (.clk_sys(clk_sys), .nrst(nrst), .flip_req(flip_req),
      .gate_req(gate_req), .cmp_out(cmp_out), .comparator_source_gate(comparator_source_gate));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and drive tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One bus cycle per call, so consecutive calls give back-to-back strobes
   task automatic cyc(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_wr <= w;
      sfr_rd <= rd;
      sfr_addr <= a;
      sfr_wdata <= d;
      if (rd) exp_q.push_back((a == 8'h9d) ? shadow : 8'h00);
      if (w && a == 8'h9d) shadow = d & 8'h33;
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic flip();
      @(posedge clk_sys);
      flip_req <= 1'b1;
      @(posedge clk_sys);
      flip_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic clr(input logic rc, input logic fc);
      @(posedge clk_sys);
      rise_flag_clr <= rc;
      fall_flag_clr <= fc;
      @(posedge clk_sys);
      rise_flag_clr <= 1'b0;
      fall_flag_clr <= 1'b0;
      idle(2);
   endtask
   task automatic flags(input logic [2:0] e);
      #1;
      chk({5'h0, rise_edge_flag, fall_edge_flag, cmp_irq_req}, {5'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Read monitor: a result appears the cycle after each read strobe
   always @(posedge clk_sys) rd_pend <= sfr_rd;
   always @(negedge clk_sys) begin
      if (rd_pend && exp_q.size() > 0) chk(sfr_rdata, exp_q.pop_front());
      else if (nrst) chk(sfr_rdata, 8'h00);
   end
   // Watchdog, far beyond the roughly 105 cycles the sequence needs
   initial begin
      #(5000 * 8);
      err_total++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      idle(1);
      #1 chk({6'h0, response_time_sel}, 8'h02);
      cyc(1'b0, 1'b1, 8'h9d, 8'h00);
      cyc(1'b1, 1'b0, 8'h9d, 8'h7f);
      cyc(1'b0, 1'b1, 8'h9d, 8'h00);
      cyc(1'b0, 1'b1, 8'h9c, 8'h00);
      for (int k = 0; k < 4; k++) begin
         cyc(1'b1, 1'b0, 8'h9d, 8'(k));
         idle(1);
         #1 chk({6'h0, response_time_sel}, 8'(k));
      end
      // Random traffic; bit 7 kept at 0 as software must
      repeat (40) begin
         r = $random(seed);
         cyc(r[0], ~r[0], r[8] ? 8'h9d : r[23:16], r[15:8] & 8'h7f);
      end
      cyc(1'b1, 1'b0, 8'h9d, 8'h30);
      gate_req <= 1'b1;
      idle(2);
      flip();
      flags(3'b101);
      idle(6);
      flags(3'b101);
      gate_req <= 1'b0;
      idle(2);
      flags(3'b100);
      gate_req <= 1'b1;
      cyc(1'b1, 1'b0, 8'h9d, 8'h10);
      idle(2);
      flags(3'b100);
      flip();
      flags(3'b111);
      cyc(1'b1, 1'b0, 8'h9d, 8'h00);
      idle(2);
      flags(3'b110);
      clr(1'b1, 1'b0);
      flags(3'b010);
      cyc(1'b1, 1'b0, 8'h9d, 8'h10);
      idle(2);
      flags(3'b011);
      clr(1'b0, 1'b1);
      flags(3'b000);
      // Mid-run reset must bring every field back to its reset value
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b0;
      idle(2);
      flags(3'b000);
      nrst <= 1'b1;
      shadow = 8'h02;
      idle(1);
      #1 chk({6'h0, response_time_sel}, 8'h02);
      cyc(1'b0, 1'b1, 8'h9d, 8'h00);
      idle(2);
      give_verdict();
   end
endmodule
`default_nettype wire
